/* File: mrr_bus_master.sv */
// Purpose: two-wire bus master model driving the monitor's serial pins
// Assumes: open-drain lines resolved by the bench, pulled up
// Notes: phases are at least 10 system clocks, well above the 6-clock minimum
`timescale 1ns/1ps
module mrr_bus_master (
   input wire logic clock_i,
   input wire logic sda_i,
   output logic scl_low_o,
   output logic sda_low_o
);
   localparam int HALF = 10;
   initial begin
      scl_low_o = 1'b0;
      sda_low_o = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask
   // serves as start and as repeated start
   task automatic start();
      sda_low_o = 1'b0;
      tick(HALF);
      scl_low_o = 1'b0;
      tick(HALF);
      sda_low_o = 1'b1;
      tick(HALF);
      scl_low_o = 1'b1;
      tick(2);
   endtask
   task automatic stop();
      scl_low_o = 1'b1;
      tick(2);
      sda_low_o = 1'b1;
      tick(HALF);
      scl_low_o = 1'b0;
      tick(HALF);
      sda_low_o = 1'b0;
      tick(HALF);
   endtask
   // data changes only while the clock is low, sampled late in the high phase
   task automatic bitx(input logic b, output logic r);
      sda_low_o = ~b;
      tick(HALF);
      scl_low_o = 1'b0;
      tick(HALF);
      r = sda_i;
      scl_low_o = 1'b1;
      tick(2);
   endtask
   task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] r,
                       output logic k);
      for (int i = 7; i >= 0; i--) bitx(d[i], r[i]);
      bitx(a, k);
   endtask
   // ack phase with the clock held high, so only the data line sits low
   task automatic ack_hold(input int n);
      sda_low_o = 1'b0;
      tick(HALF);
      scl_low_o = 1'b0;
      tick(n);
   endtask
endmodule // mrr_bus_master

/* File: mrr_defines.svh */
// Purpose: named constants of the monitor register readout block
// Assumes: included by bare name from every file that needs them
// Notes: register indices are the printed pointer values
`ifndef MRR_DEFINES_SVH
`define MRR_DEFINES_SVH
`define MRR_PTR_W 3
`define MRR_REG_SUP_HI 3'h2
`define MRR_REG_SUP_LO 3'h3
`define MRR_REG_AUX_HI 3'h4
`define MRR_REG_AUX_LO 3'h5
`define MRR_REG_CTRL 3'h6
`define MRR_PTR_ZERO 3'h0
`define MRR_PTR_STEP 3'h1
`define MRR_BIT_SNAP 7
`define MRR_BIT_CH_HI 6
`define MRR_BIT_CH_LO 5
`define MRR_BIT_TEST 4
`define MRR_BIT_PAGE 3
`define MRR_BIT_STUCK 2
`define MRR_CTRL_RST 8'h0c
`define MRR_CTRL_MASK 8'hfc
`define MRR_LOW_PAD 3'h0
`define MRR_BYTE_ZERO 8'h00
`define MRR_DEV_ADDR 7'h67
`define MRR_MASS_ADDR 7'h66
`define MRR_BITS_BYTE 4'h8
`define MRR_CNT_ZERO 4'h0
`define MRR_CNT_STEP 4'h1
`define MRR_STUCK_US 33000
`define MRR_CLK_MHZ 25
`define MRR_STUCK_CYC (`MRR_STUCK_US * `MRR_CLK_MHZ)
`define MRR_STUCK_W 20
`endif

/* File: mrr_line_if.sv */
// Purpose: synchronised bus lines and stuck-bus timer link
// Assumes: one clock domain
// Notes: carries levels only
`timescale 1ns/1ps
interface mrr_line_if;
   logic scl;
   logic sda;
   logic timer_en;
   logic stuck;
   modport src (output scl, output sda);
   modport tmr (input scl, input sda, input timer_en, output stuck);
   modport core (input scl, input sda, input stuck, output timer_en);
endinterface

/* File: mrr_monitor_regs.sv */
// Purpose: register bank and two-wire serial slave of a power monitor
// Assumes: converter outside; open-drain data pin resolved outside
// Notes: sense registers 0/1 and pointer 7 read as zero
// What this block does
// - supply result twelve bits, high then low
// - aux result twelve bits, high then low
// - low byte bit3 shows snapshot busy
// - reserved bits read zero, ignore writes
// - snapshot converts only the selected channel
// - snapshot done clears busy, halts converter
// - snapshot and test mode off means converter runs free
// - control bits 6:5 select snapshot channel
// - test mode halts converter, allows result writes
// - page bit defaults on, enables auto-increment
// - stuck timer enable defaults on
// - repeated start with read bit returns register
// - master ack fetches next register byte
// - stop ends transfer, pointer returns zero
// - command byte loads only three pointer bits
// - line low too long resets serial machine
`timescale 1ns/1ps
`include "mrr_defines.svh"
module mrr_monitor_regs #(
   parameter int unsigned STUCK_CYCLES = `MRR_STUCK_CYC
) (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   input wire logic conv_done_i,
   input wire mrr_pkg::mrr_chan_t conv_chan_i,
   input wire logic [11:0] conv_data_i,
   output logic conv_run_o,
   output logic conv_start_o,
   output mrr_pkg::mrr_chan_t conv_sel_o
);
   import mrr_pkg::*;
   mrr_line_if line_if();
   mrr_sync u_sync (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .scl_i(scl_i),
      .sda_i(sda_i),
      .line(line_if.src)
   );
   mrr_stuck_timer #(.STUCK_CYCLES(STUCK_CYCLES)) u_timer (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .line(line_if.tmr)
   );
   // register bank state
   logic [7:0] ctrl_ff, nxt_ctrl;
   logic [11:0] sup_ff, nxt_sup;
   logic [11:0] aux_ff, nxt_aux;
   logic sup_busy_ff, nxt_sup_busy;
   logic aux_busy_ff, nxt_aux_busy;
   logic start_ff, nxt_start;
   // serial state
   mrr_state_t state_ff, nxt_state;
   logic [3:0] cnt_ff, nxt_cnt;
   logic [7:0] shift_ff, nxt_shift;
   logic [7:0] tx_ff, nxt_tx;
   logic [2:0] ptr_ff, nxt_ptr;
   logic rw_ff, nxt_rw;
   logic wrote_ff, nxt_wrote;
   logic mack_ff, nxt_mack;
   logic drive_ff, nxt_drive;
   logic scl_d_ff, sda_d_ff;
   // write strobe from the serial side to the bank
   logic wr_en;
   logic [2:0] wr_ptr;
   logic [7:0] wr_data;
   logic scl_rise, scl_fall, start_det, stop_det;
   logic snap_en, test_en, page_en;
   mrr_chan_t sel;
   // bytes at the pointer and at the stepped pointer, for the transmit shifter
   logic [7:0] rd_cur, rd_nxt;

   function automatic logic [7:0] low_byte(input logic [11:0] d, input logic busy);
      return {d[3:0], busy, `MRR_LOW_PAD};
   endfunction
   function automatic logic [7:0] rd_reg(input logic [2:0] a);
      case (a)
         `MRR_REG_SUP_HI: rd_reg = sup_ff[11:4];
         `MRR_REG_SUP_LO: rd_reg = low_byte(sup_ff, sup_busy_ff);
         `MRR_REG_AUX_HI: rd_reg = aux_ff[11:4];
         `MRR_REG_AUX_LO: rd_reg = low_byte(aux_ff, aux_busy_ff);
         `MRR_REG_CTRL: rd_reg = ctrl_ff & `MRR_CTRL_MASK;
         default: rd_reg = `MRR_BYTE_ZERO;
      endcase
   endfunction
   function automatic logic [2:0] step(input logic [2:0] p, input logic en);
      return en ? p + `MRR_PTR_STEP : p;
   endfunction
   assign snap_en = ctrl_ff[`MRR_BIT_SNAP];
   assign test_en = ctrl_ff[`MRR_BIT_TEST];
   assign page_en = ctrl_ff[`MRR_BIT_PAGE];
   assign sel = mrr_chan_t'(ctrl_ff[`MRR_BIT_CH_HI:`MRR_BIT_CH_LO]);
   assign line_if.timer_en = ctrl_ff[`MRR_BIT_STUCK];
   assign scl_rise = line_if.scl && !scl_d_ff;
   assign scl_fall = !line_if.scl && scl_d_ff;
   assign start_det = scl_d_ff && line_if.scl && sda_d_ff && !line_if.sda;
   assign stop_det = scl_d_ff && line_if.scl && !sda_d_ff && line_if.sda;
   // converter control: free run unless snapshot or test mode
   assign conv_run_o = !snap_en && !test_en;
   assign conv_start_o = start_ff;
   assign conv_sel_o = sel;
   // open drain: only ever pull low
   assign sda_o = 1'b0;
   assign sda_oe_o = drive_ff;
   // register bank next state
   always_comb begin
      nxt_ctrl = ctrl_ff;
      nxt_sup = sup_ff;
      nxt_aux = aux_ff;
      nxt_sup_busy = sup_busy_ff;
      nxt_aux_busy = aux_busy_ff;
      nxt_start = start_ff;
      if (ce_i) begin
         nxt_start = 1'b0;
         if (conv_done_i && !test_en) begin
            if (conv_chan_i == MRR_CH_SUPPLY) nxt_sup = conv_data_i;
            if (conv_chan_i == MRR_CH_AUX) nxt_aux = conv_data_i;
         end
         if (conv_done_i && snap_en && conv_chan_i == sel) begin
            if (sel == MRR_CH_SUPPLY) nxt_sup_busy = 1'b0;
            if (sel == MRR_CH_AUX) nxt_aux_busy = 1'b0;
         end
         if (wr_en) begin
            case (wr_ptr)
               `MRR_REG_CTRL: nxt_ctrl = wr_data & `MRR_CTRL_MASK;
               `MRR_REG_SUP_HI: if (test_en) nxt_sup[11:4] = wr_data;
               `MRR_REG_SUP_LO: if (test_en) nxt_sup[3:0] = wr_data[7:4];
               `MRR_REG_AUX_HI: if (test_en) nxt_aux[11:4] = wr_data;
               `MRR_REG_AUX_LO: if (test_en) nxt_aux[3:0] = wr_data[7:4];
               default: ;
            endcase
            // set after clear so a new request is never lost
            if (wr_ptr == `MRR_REG_CTRL && wr_data[`MRR_BIT_SNAP]
                && !wr_data[`MRR_BIT_TEST]) begin
               nxt_start = 1'b1;
               case (mrr_chan_t'(wr_data[`MRR_BIT_CH_HI:`MRR_BIT_CH_LO]))
                  MRR_CH_SUPPLY: nxt_sup_busy = 1'b1;
                  MRR_CH_AUX: nxt_aux_busy = 1'b1;
                  default: ;
               endcase
            end
         end
      end
   end
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         ctrl_ff <= `MRR_CTRL_RST;
         sup_ff <= '0;
         aux_ff <= '0;
         sup_busy_ff <= 1'b0;
         aux_busy_ff <= 1'b0;
         start_ff <= 1'b0;
      end else begin
         ctrl_ff <= nxt_ctrl;
         sup_ff <= nxt_sup;
         aux_ff <= nxt_aux;
         sup_busy_ff <= nxt_sup_busy;
         aux_busy_ff <= nxt_aux_busy;
         start_ff <= nxt_start;
      end
   end
   // serial slave next state; data is driven after scl falls, released at once on start, stop or stuck
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_shift = shift_ff;
      nxt_tx = tx_ff;
      nxt_ptr = ptr_ff;
      nxt_rw = rw_ff;
      nxt_wrote = wrote_ff;
      nxt_mack = mack_ff;
      nxt_drive = drive_ff;
      wr_en = 1'b0;
      wr_ptr = ptr_ff;
      wr_data = shift_ff;
      rd_cur = rd_reg(ptr_ff);
      rd_nxt = rd_reg(step(ptr_ff, page_en));
      if (ce_i) begin
         if (line_if.stuck || stop_det) begin
            nxt_state = MRR_ST_IDLE;
            nxt_drive = 1'b0;
            nxt_ptr = `MRR_PTR_ZERO;
         end else if (start_det) begin
            nxt_state = MRR_ST_ADDR;
            nxt_cnt = `MRR_CNT_ZERO;
            nxt_drive = 1'b0;
         end else if (scl_rise) begin
            case (state_ff)
               MRR_ST_ADDR, MRR_ST_CMD, MRR_ST_WR: begin
                  nxt_shift = {shift_ff[6:0], line_if.sda};
                  nxt_cnt = cnt_ff + `MRR_CNT_STEP;
               end
               MRR_ST_TX: nxt_cnt = cnt_ff + `MRR_CNT_STEP;
               MRR_ST_MACK: nxt_mack = !line_if.sda;
               default: ;
            endcase
         end else if (scl_fall) begin
            case (state_ff)
               MRR_ST_ADDR: begin
                  if (cnt_ff == `MRR_BITS_BYTE) begin
                     nxt_rw = shift_ff[0];
                     if (shift_ff[7:1] == `MRR_DEV_ADDR
                         || (shift_ff[7:1] == `MRR_MASS_ADDR && !shift_ff[0])) begin
                        nxt_state = MRR_ST_AACK;
                        nxt_drive = 1'b1;
                     end else begin
                        nxt_state = MRR_ST_IDLE;
                     end
                  end
               end
               MRR_ST_AACK: begin
                  nxt_cnt = `MRR_CNT_ZERO;
                  if (rw_ff) begin
                     nxt_state = MRR_ST_TX;
                     nxt_tx = {rd_cur[6:0], 1'b0};
                     nxt_drive = !rd_cur[7];
                  end else begin
                     nxt_state = MRR_ST_CMD;
                     nxt_drive = 1'b0;
                  end
               end
               MRR_ST_CMD: begin
                  if (cnt_ff == `MRR_BITS_BYTE) begin
                     nxt_ptr = shift_ff[2:0];
                     nxt_state = MRR_ST_CACK;
                     nxt_drive = 1'b1;
                  end
               end
               MRR_ST_CACK: begin
                  nxt_state = MRR_ST_WR;
                  nxt_cnt = `MRR_CNT_ZERO;
                  nxt_wrote = 1'b0;
                  nxt_drive = 1'b0;
               end
               MRR_ST_WR: begin
                  if (cnt_ff == `MRR_BITS_BYTE) begin
                     // without page mode only the first byte is taken
                     if (!wrote_ff || page_en) begin
                        wr_en = 1'b1;
                        nxt_wrote = 1'b1;
                        nxt_state = MRR_ST_WACK;
                        nxt_drive = 1'b1;
                     end else begin
                        nxt_state = MRR_ST_IDLE;
                     end
                  end
               end
               MRR_ST_WACK: begin
                  nxt_state = MRR_ST_WR;
                  nxt_cnt = `MRR_CNT_ZERO;
                  nxt_drive = 1'b0;
                  nxt_ptr = step(ptr_ff, page_en);
               end
               MRR_ST_TX: begin
                  if (cnt_ff == `MRR_BITS_BYTE) begin
                     nxt_state = MRR_ST_MACK;
                     nxt_drive = 1'b0;
                     nxt_mack = 1'b0;
                  end else begin
                     nxt_drive = !tx_ff[7];
                     nxt_tx = {tx_ff[6:0], 1'b0};
                  end
               end
               MRR_ST_MACK: begin
                  if (mack_ff) begin
                     nxt_state = MRR_ST_TX;
                     nxt_cnt = `MRR_CNT_ZERO;
                     nxt_ptr = step(ptr_ff, page_en);
                     nxt_tx = {rd_nxt[6:0], 1'b0};
                     nxt_drive = !rd_nxt[7];
                  end else begin
                     nxt_state = MRR_ST_IDLE;
                  end
               end
               default: nxt_state = MRR_ST_IDLE;
            endcase
         end
      end
   end
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         state_ff <= MRR_ST_IDLE;
         cnt_ff <= `MRR_CNT_ZERO;
         shift_ff <= `MRR_BYTE_ZERO;
         tx_ff <= `MRR_BYTE_ZERO;
         ptr_ff <= `MRR_PTR_ZERO;
         rw_ff <= 1'b0;
         wrote_ff <= 1'b0;
         mack_ff <= 1'b0;
         drive_ff <= 1'b0;
         scl_d_ff <= 1'b1;
         sda_d_ff <= 1'b1;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         shift_ff <= nxt_shift;
         tx_ff <= nxt_tx;
         ptr_ff <= nxt_ptr;
         rw_ff <= nxt_rw;
         wrote_ff <= nxt_wrote;
         mack_ff <= nxt_mack;
         drive_ff <= nxt_drive;
         scl_d_ff <= ce_i ? line_if.scl : scl_d_ff;
         sda_d_ff <= ce_i ? line_if.sda : sda_d_ff;
      end
   end
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);
   sequence s_snap_sup_req;
      ce_i && wr_en && wr_ptr == `MRR_REG_CTRL && wr_data[`MRR_BIT_SNAP]
         && !wr_data[`MRR_BIT_TEST] && wr_data[`MRR_BIT_CH_HI:`MRR_BIT_CH_LO] == 2'h1;
   endsequence
   // masks instead of selects: a function result cannot be part-selected
   property p_reserved_zero;
      (rd_reg(`MRR_REG_SUP_LO) & 8'h07) == 8'h00
         && (rd_reg(`MRR_REG_AUX_LO) & 8'h07) == 8'h00
         && (rd_reg(`MRR_REG_CTRL) & 8'h03) == 8'h00;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits nonzero");
   property p_busy_shown;
      (rd_reg(`MRR_REG_SUP_LO) & 8'h08) == {4'h0, sup_busy_ff, 3'h0}
         && (rd_reg(`MRR_REG_AUX_LO) & 8'h08) == {4'h0, aux_busy_ff, 3'h0};
   endproperty
   a_busy_shown: assert property (p_busy_shown) else $error("busy bit not shown");
   property p_snap_start;
      s_snap_sup_req |=> sup_busy_ff && conv_start_o ##1 !conv_start_o;
   endproperty
   a_snap_start: assert property (p_snap_start) else $error("snapshot did not start");
   property p_snap_done;
      ce_i && snap_en && conv_done_i && conv_chan_i == MRR_CH_SUPPLY && sel == MRR_CH_SUPPLY
         && !wr_en |=> !sup_busy_ff && !conv_run_o;
   endproperty
   a_snap_done: assert property (p_snap_done) else $error("busy not cleared");
   property p_free_run;
      !snap_en && !test_en |-> conv_run_o && conv_sel_o == sel;
   endproperty
   a_free_run: assert property (p_free_run) else $error("converter not free running");
   property p_test_hold;
      ce_i && test_en && conv_done_i && !wr_en |=> sup_ff == $past(sup_ff) && aux_ff == $past(aux_ff);
   endproperty
   a_test_hold: assert property (p_test_hold) else $error("result changed in test mode");
   property p_stop_ptr;
      ce_i && stop_det && !line_if.stuck |=> ptr_ff == 3'h0 && state_ff == MRR_ST_IDLE;
   endproperty
   a_stop_ptr: assert property (p_stop_ptr) else $error("stop kept pointer");
   property p_cmd_ptr;
      ce_i && state_ff == MRR_ST_CMD && scl_fall && cnt_ff == 4'h8 && !stop_det && !start_det
         && !line_if.stuck |=> ptr_ff == $past(shift_ff[2:0]) && sda_oe_o;
   endproperty
   a_cmd_ptr: assert property (p_cmd_ptr) else $error("pointer load wrong");
   property p_sup_update;
      ce_i && conv_done_i && conv_chan_i == MRR_CH_SUPPLY && !test_en
         |=> sup_ff == $past(conv_data_i);
   endproperty
   a_sup_update: assert property (p_sup_update) else $error("supply result not stored");
endmodule // mrr_monitor_regs

/* File: mrr_pkg.sv */
// Purpose: shared types of the monitor register readout block
// Assumes: nothing beyond the header
// Notes: one-hot serial states
package mrr_pkg;
   typedef enum logic [1:0] {
      MRR_CH_SENSE = 2'h0,
      MRR_CH_SUPPLY = 2'h1,
      MRR_CH_AUX = 2'h2,
      MRR_CH_NONE = 2'h3
   } mrr_chan_t;
   typedef enum logic [8:0] {
      MRR_ST_IDLE = 9'h001,
      MRR_ST_ADDR = 9'h002,
      MRR_ST_AACK = 9'h004,
      MRR_ST_CMD = 9'h008,
      MRR_ST_CACK = 9'h010,
      MRR_ST_WR = 9'h020,
      MRR_ST_WACK = 9'h040,
      MRR_ST_TX = 9'h080,
      MRR_ST_MACK = 9'h100
   } mrr_state_t;
endpackage

/* File: mrr_stuck_timer.sv */
// Purpose: stuck-bus timer, fires once when a line stays low too long
// Assumes: synchronised line levels
// Notes: rearms only after both lines are high or the timer enable is off
`timescale 1ns/1ps
`include "mrr_defines.svh"
module mrr_stuck_timer #(
   parameter int unsigned STUCK_CYCLES = `MRR_STUCK_CYC
) (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic ce_i,
   mrr_line_if.tmr line
);
   logic [`MRR_STUCK_W-1:0] cnt_ff;
   logic [`MRR_STUCK_W-1:0] nxt_cnt;
   logic fired_ff;
   logic nxt_fired;
   logic pulse_ff;
   logic nxt_pulse;
   always_comb begin
      nxt_cnt = cnt_ff;
      nxt_fired = fired_ff;
      // pulse held while frozen, like every other piece of state
      nxt_pulse = pulse_ff;
      if (ce_i) begin
         nxt_pulse = 1'b0;
         if ((line.scl && line.sda) || !line.timer_en) begin
            nxt_cnt = '0;
            nxt_fired = 1'b0;
         end else if (!fired_ff) begin
            if (cnt_ff == `MRR_STUCK_W'(STUCK_CYCLES)) begin
               nxt_pulse = 1'b1;
               nxt_fired = 1'b1;
            end else begin
               nxt_cnt = cnt_ff + `MRR_STUCK_W'(1);
            end
         end
      end
   end
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_ff <= '0;
         fired_ff <= 1'b0;
         pulse_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         fired_ff <= nxt_fired;
         pulse_ff <= nxt_pulse;
      end
   end
   assign line.stuck = pulse_ff;
endmodule // mrr_stuck_timer

/* File: mrr_sync.sv */
// Purpose: two-flop synchroniser for the bus clock and data pins
// Assumes: pins idle high
// Notes: only the second stage leaves this module
`timescale 1ns/1ps
module mrr_sync (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic scl_i,
   input wire logic sda_i,
   mrr_line_if.src line
);
   logic [1:0] meta_ff;
   logic [1:0] sync_ff;
   logic [1:0] nxt_meta;
   logic [1:0] nxt_sync;
   always_comb begin
      nxt_meta = ce_i ? {scl_i, sda_i} : meta_ff;
      nxt_sync = ce_i ? meta_ff : sync_ff;
   end
   // reset to idle-high so no false start is seen at release
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         meta_ff <= 2'h3;
         sync_ff <= 2'h3;
      end else begin
         meta_ff <= nxt_meta;
         sync_ff <= nxt_sync;
      end
   end
   assign line.scl = sync_ff[1];
   assign line.sda = sync_ff[0];
endmodule // mrr_sync

/* File: tb.sv */
// Purpose: self-checking bench of the monitor register readout block
// Assumes: bus master model drives the serial pins
// Notes: stuck timer shortened so the run stays short
`timescale 1ns/1ps
`include "mrr_defines.svh"
module tb;
   import mrr_pkg::*;
   localparam int unsigned STUCK = 1000;
   logic clock_i = 1'b0;
   logic rst_i = 1'b1;
   logic conv_done = 1'b0;
   mrr_chan_t conv_chan = MRR_CH_SENSE;
   logic [11:0] conv_data = 12'h000;
   logic sda_o, sda_oe, conv_run, conv_start, scl_low, sda_low;
   mrr_chan_t conv_sel;
   wire logic scl_w = ~scl_low;
   wire logic sda_w = ~(sda_low | (sda_oe & ~sda_o));
   logic [7:0] rb [0:3];
   int miscompares = 0;
   int n_tests = 0;
   int starts = 0;
   int st;
   logic [7:0] r;
   logic k;
   always #20 clock_i = ~clock_i;
   always @(posedge clock_i) if (conv_start === 1'b1) starts <= starts + 1;
   mrr_monitor_regs #(.STUCK_CYCLES(STUCK)) uut (.clock_i(clock_i), .rst_i(rst_i),
      .ce_i(1'b1), .scl_i(scl_w), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe),
      .conv_done_i(conv_done), .conv_chan_i(conv_chan), .conv_data_i(conv_data),
      .conv_run_o(conv_run), .conv_start_o(conv_start), .conv_sel_o(conv_sel));
   mrr_bus_master m (.clock_i(clock_i), .sda_i(sda_w), .scl_low_o(scl_low),
      .sda_low_o(sda_low));
   task automatic tk(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic summarize();
      if (miscompares == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] cmd, input logic [7:0] d);
      logic [7:0] q;
      logic a;
      m.start();
      m.xfer({`MRR_DEV_ADDR, 1'b0}, 1'b1, q, a);
      m.xfer(cmd, 1'b1, q, a);
      m.xfer(d, 1'b1, q, a);
      check("write ack", a, 8'h00);
      m.stop();
   endtask
   // set low skips the pointer load and reads from where a stop left it
   task automatic rd(input logic [7:0] cmd, input int n, input logic set);
      logic [7:0] q;
      logic a;
      if (set) begin
         m.start();
         m.xfer({`MRR_DEV_ADDR, 1'b0}, 1'b1, q, a);
         m.xfer(cmd, 1'b1, q, a);
      end
      m.start();
      m.xfer({`MRR_DEV_ADDR, 1'b1}, 1'b1, q, a);
      check("read ack", a, 8'h00);
      for (int i = 0; i < n; i++) m.xfer(8'hff, i == n - 1, rb[i], a);
      m.stop();
   endtask
   task automatic conv(input mrr_chan_t c, input logic [11:0] d);
      conv_chan = c;
      conv_data = d;
      conv_done = 1'b1;
      tk(1);
      conv_done = 1'b0;
      tk(2);
   endtask
   initial begin
      #2_000_000;
      miscompares++;
      summarize();
   end
   initial begin
      tk(8);
      rst_i = 1'b0;
      tk(4);
      rd(8'h06, 1, 1'b1);
      check("ctrl reset", rb[0], 8'h0c);
      check("run free", conv_run, 8'h01);
      conv(MRR_CH_SUPPLY, 12'habc);
      conv(MRR_CH_AUX, 12'h5a3);
      rd(8'hfa, 4, 1'b1);
      check("sup hi", rb[0], 8'hab);
      check("sup lo", rb[1], 8'hc0);
      check("aux hi", rb[2], 8'h5a);
      check("aux lo", rb[3], 8'h30);
      rd(8'h00, 3, 1'b0);
      check("ptr after stop", rb[2], 8'hab);
      st = starts;
      wr(8'h06, 8'hac);
      check("start pulse", 8'(starts - st), 8'h01);
      check("sel", conv_sel, MRR_CH_SUPPLY);
      check("run snap", conv_run, 8'h00);
      rd(8'h03, 1, 1'b1);
      check("busy set", rb[0], 8'hc8);
      conv(MRR_CH_AUX, 12'h111);
      rd(8'h03, 1, 1'b1);
      check("busy other", rb[0], 8'hc8);
      conv(MRR_CH_SUPPLY, 12'h123);
      rd(8'h02, 2, 1'b1);
      check("done hi", rb[0], 8'h12);
      check("done lo", rb[1], 8'h30);
      check("halted", conv_run, 8'h00);
      check("one start", 8'(starts - st), 8'h01);
      wr(8'h06, 8'hcc);
      check("sel aux", conv_sel, MRR_CH_AUX);
      rd(8'h05, 1, 1'b1);
      check("aux busy", rb[0], 8'h18);
      conv(MRR_CH_AUX, 12'h456);
      rd(8'h05, 1, 1'b1);
      check("aux done", rb[0], 8'h60);
      wr(8'h06, 8'h1f);
      rd(8'h06, 1, 1'b1);
      check("ctrl mask", rb[0], 8'h1c);
      check("test halt", conv_run, 8'h00);
      wr(8'h03, 8'hff);
      conv(MRR_CH_SUPPLY, 12'h000);
      rd(8'h03, 1, 1'b1);
      check("test write", rb[0], 8'hf0);
      wr(8'h06, 8'h04);
      check("run again", conv_run, 8'h01);
      rd(8'h02, 2, 1'b1);
      check("page off 0", rb[0], 8'h12);
      check("page off 1", rb[1], 8'h12);
      // device acks and holds data low; only the enabled timer lets go
      for (int e = 1; e >= 0; e--) begin
         wr(8'h06, e ? 8'h04 : 8'h00);
         m.start();
         for (int i = 7; i >= 0; i--) m.bitx(i == 0 ? 1'b0 : `MRR_DEV_ADDR >> (i - 1), k);
         m.ack_hold(STUCK + 100);
         check("stuck oe", sda_oe, e ? 8'h00 : 8'h01);
         m.stop();
      end
      rd(8'h06, 1, 1'b1);
      check("after stuck", rb[0], 8'h00);
      summarize();
   end
endmodule // tb
